// ===== host_regs.sv
// Host register bank: interrupt mask, byte-order probe, FIFO thresholds and
// receive configuration, reached over APB. Assumes the status register, FIFOs
// and power controller sit outside on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "host_regs_map.svh"

module host_regs
  import host_regs_pkg::*;
  (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] interrupt_status_register,
  input wire host_regs_pkg::fifo_levels_type fifo_levels,
  input wire logic rx_word_read,
  input wire logic low_power,
  output logic irq,
  output logic wake_request,
  output logic transmit_space_available_irq,
  output logic transmit_status_level_irq,
  output logic receive_status_level_irq,
  output logic receive_dma_done,
  output logic rx_flush,
  output logic [1:0] end_align,
  output logic [4:0] receive_data_offset,
  output logic [1:0] pad_words
  );

  import host_regs_pkg::*;

  logic [31:0] interrupt_mask;
  logic [7:0] space_level;
  logic [7:0] tx_status_level;
  logic [7:0] rx_status_level;
  logic [1:0] align_field;
  logic [4:0] offset_field;
  logic [2:0] pad_count;

  wire logic [11:0] receive_dma_countdown;
  wire logic dma_done_pulse;
  wire logic access;
  wire logic write_access;
  wire logic hit_mask;
  wire logic hit_probe;
  wire logic hit_level;
  wire logic hit_rx;
  wire logic hit_power;
  wire logic unmapped;
  wire logic write_mask;
  wire logic write_level;
  wire logic write_rx;
  wire logic write_probe;
  wire logic [31:0] level_word;
  wire logic [31:0] rx_word;
  wire logic [31:0] power_word;
  wire logic [31:0] read_mux;
  wire logic [31:0] next_mask;
  wire logic [31:0] pending;
  wire logic space_above;
  wire logic tx_status_above;
  wire logic rx_status_above;
  wire logic [2:0] align_words;
  wire logic setup_phase;
  wire logic read_setup;
  wire logic [31:0] next_prdata;
  wire logic next_irq;
  wire logic next_flush;
  wire logic next_wake;

  // One-cycle access phase: setup then access with pready already high.
  assign access = psel && penable;
  assign write_access = access && pwrite;
  assign hit_mask = paddr == `IRQ_MASK_OFFSET;
  assign hit_probe = paddr == `BYTE_ORDER_OFFSET;
  assign hit_level = paddr == `FIFO_LEVEL_OFFSET;
  assign hit_rx = paddr == `RX_CONFIG_OFFSET;
  assign hit_power = paddr == `POWER_STATE_OFFSET;
  assign unmapped = !(hit_mask || hit_probe || hit_level || hit_rx || hit_power);
  assign write_mask = write_access && hit_mask;
  assign write_level = write_access && hit_level;
  assign write_rx = write_access && hit_rx;
  assign write_probe = write_access && hit_probe;
  assign setup_phase = psel && !penable;
  assign read_setup = setup_phase && !pwrite;
  assign next_prdata = read_setup ? read_mux : 32'h00000000;
  assign next_wake = write_probe && low_power;
  assign next_flush = write_rx && pwdata[`RX_FLUSH_BIT];

  assign next_mask = write_mask ? (pwdata & `IRQ_MASK_WRITABLE) : interrupt_mask;

  assign level_word = {space_level, tx_status_level, 8'h00, rx_status_level};
  assign rx_word = {align_field, 2'h0, receive_dma_countdown, 1'b0, 2'h0, offset_field, 8'h00};
  assign power_word = {31'h00000000, low_power};

  assign read_mux = hit_mask ? interrupt_mask :
                    hit_probe ? `BYTE_ORDER_VALUE :
                    hit_level ? level_word :
                    hit_rx ? rx_word :
                    hit_power ? power_word : 32'h00000000;

  assign pending = interrupt_status_register & interrupt_mask;
  assign next_irq = |pending;

  assign align_words = (align_field == 2'h1) ? 3'h3 :
                       (align_field == 2'h2) ? 3'h7 : 3'h0;

  // Zero wait states: pready rises in the cycle after setup.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pready <= 1'b0;
    else
      pready <= setup_phase;
  end

  // An unmapped address answers with an error beside pready.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pslverr <= 1'b0;
    else
      pslverr <= setup_phase && unmapped;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else
      prdata <= next_prdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      interrupt_mask <= `IRQ_MASK_RESET;
    else
      interrupt_mask <= next_mask;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      space_level <= `SPACE_LEVEL_RESET;
      tx_status_level <= `TX_STATUS_LEVEL_RESET;
      rx_status_level <= `RX_STATUS_LEVEL_RESET;
    end
    else if (write_level)
    begin
      space_level <= pwdata[`SPACE_LEVEL_MSB:`SPACE_LEVEL_LSB];
      tx_status_level <= pwdata[`TX_STATUS_LEVEL_MSB:`TX_STATUS_LEVEL_LSB];
      rx_status_level <= pwdata[`RX_STATUS_LEVEL_MSB:`RX_STATUS_LEVEL_LSB];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      align_field <= 2'h0;
      offset_field <= 5'h00;
    end
    else if (write_rx)
    begin
      align_field <= pwdata[`END_ALIGN_MSB:`END_ALIGN_LSB];
      offset_field <= pwdata[`DATA_OFFSET_MSB:`DATA_OFFSET_LSB];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      receive_data_offset <= 5'h00;
    else if (rx_word_read || rx_flush)
      receive_data_offset <= offset_field;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      end_align <= 2'h0;
    else
      end_align <= align_field;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pad_count <= 3'h0;
    else
      pad_count <= align_words;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      pad_words <= 2'h0;
    else
      pad_words <= pad_count[2:1];
  end

  dma_countdown countdown
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(write_rx),
    .load_value(pwdata[`DMA_COUNT_MSB:`DMA_COUNT_LSB]),
    .word_read(rx_word_read),
    .count(receive_dma_countdown),
    .done(dma_done_pulse)
  );

  level_compare #(.WIDTH(8)) space_cmp
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .level(fifo_levels.space_blocks),
    .limit(space_level),
    .above(space_above)
  );

  level_compare #(.WIDTH(8)) tx_status_cmp
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .level(fifo_levels.tx_status_words),
    .limit(tx_status_level),
    .above(tx_status_above)
  );

  level_compare #(.WIDTH(8)) rx_status_cmp
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .level(fifo_levels.rx_status_words),
    .limit(rx_status_level),
    .above(rx_status_above)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      rx_flush <= 1'b0;
    else
      rx_flush <= next_flush;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      wake_request <= 1'b0;
    else
      wake_request <= next_wake;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      receive_dma_done <= 1'b0;
    else
      receive_dma_done <= dma_done_pulse;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      transmit_space_available_irq <= 1'b0;
    else
      transmit_space_available_irq <= space_above;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      transmit_status_level_irq <= 1'b0;
    else
      transmit_status_level_irq <= tx_status_above;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      receive_status_level_irq <= 1'b0;
    else
      receive_status_level_irq <= rx_status_above;
  end

endmodule

`default_nettype wire

// ===== host_regs_map.svh
// Offsets, field positions, reset values and interrupt source bits of the host register bank.
// Included by the package and the register bank; holds definitions only.
`ifndef HOST_REGS_MAP_SVH
`define HOST_REGS_MAP_SVH

`define IRQ_MASK_OFFSET 8'h5C
`define BYTE_ORDER_OFFSET 8'h64
`define FIFO_LEVEL_OFFSET 8'h68
`define RX_CONFIG_OFFSET 8'h6C
`define POWER_STATE_OFFSET 8'h78

`define BYTE_ORDER_VALUE 32'h87654321
`define IRQ_MASK_WRITABLE 32'h83BFE7DF
`define IRQ_MASK_RESET 32'h00000000
`define SPACE_LEVEL_RESET 8'h48
`define TX_STATUS_LEVEL_RESET 8'h00
`define RX_STATUS_LEVEL_RESET 8'h00

`define SPACE_LEVEL_MSB 31
`define SPACE_LEVEL_LSB 24
`define TX_STATUS_LEVEL_MSB 23
`define TX_STATUS_LEVEL_LSB 16
`define RX_STATUS_LEVEL_MSB 7
`define RX_STATUS_LEVEL_LSB 0

`define END_ALIGN_MSB 31
`define END_ALIGN_LSB 30
`define DMA_COUNT_MSB 27
`define DMA_COUNT_LSB 16
`define RX_FLUSH_BIT 15
`define DATA_OFFSET_MSB 12
`define DATA_OFFSET_LSB 8
`define DMA_DONE_SOURCE_BIT 20
`define SPACE_AVAIL_SOURCE_BIT 9
`define TX_STATUS_LEVEL_SOURCE_BIT 7
`define RX_STATUS_LEVEL_SOURCE_BIT 3

`endif

// ===== host_regs_pkg.sv
// Types shared by the host register bank and its neighbours.
// Assumes the map header is on the include path.
`include "host_regs_map.svh"

package host_regs_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_request_type;

  typedef struct packed {
    logic [7:0] space_blocks;
    logic [7:0] tx_status_words;
    logic [7:0] rx_status_words;
  } fifo_levels_type;

  typedef struct packed {
    logic [1:0] end_align;
    logic [4:0] data_offset;
    logic flush_pulse;
  } rx_control_type;

  typedef enum logic [1:0] {
    align_4 = 2'h0,
    align_16 = 2'h1,
    align_32 = 2'h2,
    align_reserved = 2'h3
  } end_align_type;

  typedef enum logic [2:0] {
    apb_idle = 3'h1,
    apb_setup = 3'h2,
    apb_access = 3'h4
  } apb_state_type;

endpackage

// ===== level_compare.sv
// Threshold comparator: raises its flag when a level exceeds a limit.
// Assumes level and limit are same-clock register values.
`timescale 1ns/1ps
`default_nettype none

module level_compare
  #(parameter int WIDTH = 8)
  (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] limit,
  output logic above
  );

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      above <= 1'b0;
    else
      above <= level > limit;
  end

endmodule

`default_nettype wire

// ===== dma_countdown.sv
// Receive DMA word countdown with reload and done pulse.
// Assumes word reads are one-cycle same-clock strobes.
`timescale 1ns/1ps
`default_nettype none

module dma_countdown
  (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [11:0] load_value,
  input wire logic word_read,
  output logic [11:0] count,
  output logic done
  );

  wire logic last_word;
  wire logic [11:0] next_count;

  assign last_word = word_read && (count == 12'h001) && !load;
  assign next_count = load ? load_value : (word_read && count != 12'h000) ? count - 12'h001 : count;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      count <= 12'h000;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= last_word;
    end
  end

endmodule

`default_nettype wire

// ===== host_regs_chk.sv
// Assertion checker for the host register bank.
// Bound to host_regs; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module host_regs_chk
  import host_regs_pkg::*;
  (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [31:0] interrupt_status_register,
  input wire host_regs_pkg::fifo_levels_type fifo_levels,
  input wire logic rx_word_read,
  input wire logic low_power,
  input wire logic irq,
  input wire logic wake_request,
  input wire logic rx_flush,
  input wire logic receive_dma_done,
  input wire logic transmit_space_available_irq,
  input wire logic transmit_status_level_irq
  );
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    pready && pwrite && paddr == a;
  endsequence
  property p_probe;
    s_rd(8'h64) |-> prdata == 32'h87654321;
  endproperty
  a_probe: assert property (p_probe) else $error("probe read wrong");
  property p_mask_rsv;
    s_rd(8'h5C) |-> (prdata & 32'h7C401820) == 32'h0;
  endproperty
  a_mask_rsv: assert property (p_mask_rsv) else $error("reserved mask bit set");
  property p_irq;
    interrupt_status_register == 32'h0 |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without status");
  property p_wake;
    wake_request |-> $past(pready && pwrite && paddr == 8'h64 && low_power);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without probe write");
  property p_flush;
    rx_flush |-> $past(pready && pwrite && paddr == 8'h6C && pwdata[15]);
  endproperty
  a_flush: assert property (p_flush) else $error("flush without write");
  property p_flush_once;
    rx_flush |=> !rx_flush;
  endproperty
  a_flush_once: assert property (p_flush_once) else $error("flush too long");
  property p_dma;
    receive_dma_done |-> $past(rx_word_read) || $past(rx_word_read, 2)
      || $past(rx_word_read, 3);
  endproperty
  a_dma: assert property (p_dma) else $error("done without read");
  property p_space;
    (fifo_levels.space_blocks == 8'h00) [*3] |-> !transmit_space_available_irq;
  endproperty
  a_space: assert property (p_space) else $error("space flag at zero");
  property p_tsl;
    (fifo_levels.tx_status_words == 8'h00) [*3] |-> !transmit_status_level_irq;
  endproperty
  a_tsl: assert property (p_tsl) else $error("status flag at zero");
endmodule
bind host_regs host_regs_chk u_chk
(
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .interrupt_status_register(interrupt_status_register),
  .fifo_levels(fifo_levels),
  .rx_word_read(rx_word_read),
  .low_power(low_power),
  .irq(irq),
  .wake_request(wake_request),
  .rx_flush(rx_flush),
  .receive_dma_done(receive_dma_done),
  .transmit_space_available_irq(transmit_space_available_irq),
  .transmit_status_level_irq(transmit_status_level_irq)
);
`default_nettype wire

// ===== irq_mask_fifo_level_rx_config_test.sv
// Self-checking bench for the host register bank over APB.
// Assumes package, header and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module irq_mask_fifo_level_rx_config_test;
  import host_regs_pkg::*;
  logic clk_sys, reset_n, psel, penable, pwrite, rx_word_read, low_power, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, interrupt_status_register, x, r, m, s, t;
  logic pready, pslverr, irq, wake_request, rx_flush, receive_dma_done;
  logic transmit_space_available_irq, transmit_status_level_irq;
  logic receive_status_level_irq;
  logic [1:0] end_align, pad_words;
  logic [4:0] receive_data_offset;
  fifo_levels_type fifo_levels;
  int error_cnt, total_checks, n_done, n_flush, n_wake;
  host_regs dut
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .interrupt_status_register(interrupt_status_register),
    .fifo_levels(fifo_levels),
    .rx_word_read(rx_word_read),
    .low_power(low_power),
    .irq(irq),
    .wake_request(wake_request),
    .transmit_space_available_irq(transmit_space_available_irq),
    .transmit_status_level_irq(transmit_status_level_irq),
    .receive_status_level_irq(receive_status_level_irq),
    .receive_dma_done(receive_dma_done),
    .rx_flush(rx_flush),
    .end_align(end_align),
    .receive_data_offset(receive_data_offset),
    .pad_words(pad_words)
  );
  initial
  begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (reset_n)
    begin
      n_done += receive_dma_done;
      n_flush += rx_flush;
      n_wake += wake_request;
    end
  end
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [1:0] pad_of(input logic [1:0] a);
    return (a == 2'h0) ? 2'h0 : (a == 2'h1) ? 2'h1 : 2'h3;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_word();
    rx_word_read <= 1'b1;
    @(posedge clk_sys);
    rx_word_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #40000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    x = 32'h46;
    {reset_n, psel, penable, pwrite, paddr, pwdata, rx_word_read, low_power} <= '0;
    interrupt_status_register <= '0;
    fifo_levels <= '0;
    cyc(10);
    reset_n <= 1'b1;
    cyc(2);
    apb(0, 8'h5C, 0);
    chk("mask", r, 0);
    apb(0, 8'h68, 0);
    chk("levels", r, 32'h48000000);
    apb(0, 8'h6C, 0);
    chk("rxcfg", r, 0);
    low_power <= 1'b1;
    cyc(4);
    chk("idle wake", n_wake, 0);
    apb(1, 8'h64, xs());
    cyc(2);
    chk("wake", n_wake, 1);
    apb(0, 8'h78, 0);
    chk("power", r, 1);
    low_power <= 1'b0;
    apb(1, 8'h64, xs());
    apb(0, 8'h64, 0);
    chk("probe", r, 32'h87654321);
    chk("no wake", n_wake, 1);
    apb(0, 8'h40, 0);
    chk("unmapped err", e, 1);
    chk("unmapped", r, 0);
    for (int i = 0; i < 6; i++)
    begin
      m = (i == 0) ? 32'hFFFFFFFF : xs();
      s = (i == 0) ? 32'h7C401820 : xs();
      apb(1, 8'h5C, m);
      apb(0, 8'h5C, 0);
      chk("mask rd", r, m & 32'h83BFE7DF);
      interrupt_status_register <= s;
      cyc(3);
      chk("irq", irq, |(s & m & 32'h83BFE7DF));
    end
    for (int i = 0; i < 4; i++)
    begin
      t = xs();
      m = xs();
      apb(1, 8'h68, t);
      apb(0, 8'h68, 0);
      chk("thr rd", r, t & 32'hFFFF00FF);
      fifo_levels <= (i == 0) ? {t[31:16], t[7:0]} : m[23:0];
      cyc(4);
      chk("space", transmit_space_available_irq, fifo_levels[23:16] > t[31:24]);
      chk("txs", transmit_status_level_irq, fifo_levels[15:8] > t[23:16]);
      chk("rxs", receive_status_level_irq, fifo_levels[7:0] > t[7:0]);
    end
    for (int a = 0; a < 3; a++)
    begin
      apb(1, 8'h6C, a << 30);
      cyc(3);
      chk("align", end_align, a);
      chk("pad", pad_words, pad_of(a));
    end
    apb(1, 8'h6C, 32'h00031C00);
    rd_word();
    rd_word();
    apb(0, 8'h6C, 0);
    chk("count", r[27:16], 1);
    chk("offset", receive_data_offset, 5'h1C);
    apb(1, 8'h6C, 32'h00020000);
    rd_word();
    cyc(4);
    chk("early done", n_done, 0);
    chk("offset0", receive_data_offset, 0);
    rd_word();
    cyc(4);
    chk("done", n_done, 1);
    apb(1, 8'h6C, 32'h00008000);
    cyc(2);
    chk("flush", n_flush, 1);
    apb(0, 8'h6C, 0);
    chk("flush rd", r[15], 0);
    end_of_test();
  end
endmodule
`default_nettype wire
